/* hw/dms_decoder.sv */
/*
  Fetch and execute sequencer for the data-move and stack opcode group.
  Assumes memory on the same clock answers each held strobe by raising
  ready for one cycle with read data valid in that cycle.
*/
`timescale 1ns/1ps
module dms_decoder
  import dms_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // System bus
  output dms_bus_req_t o_bus,
  input dms_bus_rsp_t i_bus,
  // Observed state
  output dms_arch_t o_arch,
  output logic o_unsupported
);

  typedef struct packed {
    dms_state_t state;
    logic [7:0] ir;
    dms_arch_t arch;
    dms_bus_req_t bus;
    logic unsupported;
  } dms_core_t;

  dms_core_t s;
  dms_core_t next_s;
  logic busy;
  logic ack;
  logic [15:0] hl;

  // Slot of the upper byte of a pair; word code selects accumulator
  function automatic logic [2:0] hi_idx(input logic [1:0] rp);
    hi_idx = (rp == DMS_RP_WORD) ? DMS_IDX_ACC : {rp, 1'b0};
  endfunction : hi_idx

  // Slot of the lower byte of a pair; word code selects flags
  function automatic logic [2:0] lo_idx(input logic [1:0] rp);
    lo_idx = (rp == DMS_RP_WORD) ? DMS_IDX_FLAGS : {rp, 1'b1};
  endfunction : lo_idx

  // Bus handshake and memory pointer
  assign busy = s.bus.rd | s.bus.wr;
  assign ack = busy & i_bus.ready;
  assign hl = {s.arch.regs[DMS_IDX_H], s.arch.regs[DMS_IDX_L]};

  // Next-state logic
  always_comb
  begin
    next_s = s;
    next_s.unsupported = 1'b0;
    unique case (s.state)
      DMS_ST_FETCH:
      begin
        if (!busy)
        begin
          next_s.bus.rd = 1'b1;
          next_s.bus.addr = s.arch.pc;
        end
        else if (ack)
        begin
          next_s.bus.rd = 1'b0;
          next_s.ir = i_bus.rdata;
          next_s.arch.pc = s.arch.pc + 16'h0001;
          next_s.state = DMS_ST_EXEC;
        end
      end
      DMS_ST_EXEC:
      begin
        next_s.state = DMS_ST_FETCH;
        if (s.ir[7:6] == DMS_GRP_COPY)
        begin
          if (s.ir == DMS_OP_MEM_MEM)
            next_s.unsupported = 1'b1;
          else if (s.ir[5:3] == DMS_IDX_MEM)
            next_s.state = DMS_ST_WR_HL; // RL2
          else if (s.ir[2:0] == DMS_IDX_MEM)
            next_s.state = DMS_ST_RD_HL; // RL3
          else
            next_s.arch.regs[s.ir[5:3]] = s.arch.regs[s.ir[2:0]]; // RL1
        end
        else if (s.ir[7:6] == DMS_GRP_LOW && s.ir[3:0] == DMS_LOW_PAIR_IMM
                 && s.ir[5:4] != DMS_RP_WORD)
          next_s.state = DMS_ST_IMM_LO; // RL4
        else if (s.ir == DMS_OP_SWAP)
        begin
          next_s.arch.regs[DMS_IDX_D] = s.arch.regs[DMS_IDX_H]; // RL5
          next_s.arch.regs[DMS_IDX_E] = s.arch.regs[DMS_IDX_L]; // RL5
          next_s.arch.regs[DMS_IDX_H] = s.arch.regs[DMS_IDX_D]; // RL5
          next_s.arch.regs[DMS_IDX_L] = s.arch.regs[DMS_IDX_E]; // RL5
        end
        else if (s.ir[7:6] == DMS_GRP_HIGH && s.ir[3:0] == DMS_LOW_PUSH)
          next_s.state = DMS_ST_PUSH_HI; // RL6
        else if (s.ir[7:6] == DMS_GRP_HIGH && s.ir[3:0] == DMS_LOW_POP)
          next_s.state = DMS_ST_POP_LO; // RL7 RL8
        else
          next_s.unsupported = 1'b1;
      end
      DMS_ST_RD_HL:
      begin
        if (!busy)
        begin
          next_s.bus.rd = 1'b1;
          next_s.bus.addr = hl;
        end
        else if (ack)
        begin
          next_s.bus.rd = 1'b0;
          next_s.arch.regs[s.ir[5:3]] = i_bus.rdata; // RL3
          next_s.state = DMS_ST_FETCH;
        end
      end
      DMS_ST_WR_HL:
      begin
        if (!busy)
        begin
          next_s.bus.wr = 1'b1;
          next_s.bus.addr = hl;
          next_s.bus.wdata = s.arch.regs[s.ir[2:0]]; // RL2
        end
        else if (ack)
        begin
          next_s.bus.wr = 1'b0;
          next_s.state = DMS_ST_FETCH;
        end
      end
      DMS_ST_IMM_LO, DMS_ST_IMM_HI:
      begin
        if (!busy)
        begin
          next_s.bus.rd = 1'b1;
          next_s.bus.addr = s.arch.pc;
        end
        else if (ack)
        begin
          next_s.bus.rd = 1'b0;
          next_s.arch.pc = s.arch.pc + 16'h0001;
          if (s.state == DMS_ST_IMM_LO)
          begin
            next_s.arch.regs[lo_idx(s.ir[5:4])] = i_bus.rdata; // RL4
            next_s.state = DMS_ST_IMM_HI;
          end
          else
          begin
            next_s.arch.regs[hi_idx(s.ir[5:4])] = i_bus.rdata; // RL4
            next_s.state = DMS_ST_FETCH;
          end
        end
      end
      DMS_ST_PUSH_HI, DMS_ST_PUSH_LO:
      begin
        if (!busy)
        begin
          next_s.bus.wr = 1'b1;
          next_s.bus.addr = s.arch.sp - 16'h0001; // RL9
          next_s.bus.wdata = (s.state == DMS_ST_PUSH_HI) ?
            s.arch.regs[hi_idx(s.ir[5:4])] : s.arch.regs[lo_idx(s.ir[5:4])]; // RL6
        end
        else if (ack)
        begin
          next_s.bus.wr = 1'b0;
          next_s.arch.sp = s.arch.sp - 16'h0001; // RL9
          next_s.state = (s.state == DMS_ST_PUSH_HI) ? DMS_ST_PUSH_LO : DMS_ST_FETCH;
        end
      end
      DMS_ST_POP_LO, DMS_ST_POP_HI:
      begin
        if (!busy)
        begin
          next_s.bus.rd = 1'b1;
          next_s.bus.addr = s.arch.sp;
        end
        else if (ack)
        begin
          next_s.bus.rd = 1'b0;
          next_s.arch.sp = s.arch.sp + 16'h0001; // RL9
          if (s.state == DMS_ST_POP_LO)
          begin
            next_s.arch.regs[lo_idx(s.ir[5:4])] = i_bus.rdata; // RL7 RL8
            next_s.state = DMS_ST_POP_HI;
          end
          else
          begin
            next_s.arch.regs[hi_idx(s.ir[5:4])] = i_bus.rdata; // RL7 RL8
            next_s.state = DMS_ST_FETCH;
          end
        end
      end
      default:
      begin
        next_s.state = DMS_ST_FETCH;
        next_s.bus.rd = 1'b0;
        next_s.bus.wr = 1'b0;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      s.state <= DMS_ST_FETCH;
      s.ir <= DMS_REG_RESET;
      s.arch.regs <= {8{DMS_REG_RESET}};
      s.arch.sp <= DMS_SP_RESET;
      s.arch.pc <= DMS_PC_RESET;
      s.bus <= '0;
      s.unsupported <= 1'b0;
    end
    else
      s <= next_s;
  end

  // Outputs straight from flops
  assign o_bus = s.bus;
  assign o_arch = s.arch;
  assign o_unsupported = s.unsupported;

endmodule : dms_decoder

/* hw/dms_pkg.sv */
/*
  Constants, types and state encodings for the data-move and stack opcode
  decoder. Assumes a single 250 MHz clock shared with the system bus.
*/
// Operation
// (RL1) 01 DDD SSS copies register to register
// (RL2) 01110 SSS writes register to memory at HL
// (RL3) 01 DDD 110 reads memory at HL into register
// (RL4) 00 RP 0001 loads 16-bit immediate into pair; the decoder flags RP 11 as unsupported
// (RL5) 11101011 swaps pair DE with pair HL
// (RL6) 11 RP 0101 pushes pair or accumulator-flags word
// (RL7) 11 RP 0001 pops two bytes into pair
// (RL8) 11110001 pops accumulator and flag register
// (RL9) Push pre-decrements, pop post-increments stack pointer
package dms_pkg;

  // Reset values
  localparam logic [15:0] DMS_PC_RESET = 16'h0000;
  localparam logic [15:0] DMS_SP_RESET = 16'h0000;
  localparam logic [7:0] DMS_REG_RESET = 8'h00;

  // Register file slots; slot 6 holds the flags, code 6 in an opcode means memory
  localparam logic [2:0] DMS_IDX_D = 3'h2;
  localparam logic [2:0] DMS_IDX_E = 3'h3;
  localparam logic [2:0] DMS_IDX_H = 3'h4;
  localparam logic [2:0] DMS_IDX_L = 3'h5;
  localparam logic [2:0] DMS_IDX_MEM = 3'h6;
  localparam logic [2:0] DMS_IDX_FLAGS = 3'h6;
  localparam logic [2:0] DMS_IDX_ACC = 3'h7;

  // Opcode fields
  localparam logic [1:0] DMS_GRP_COPY = 2'h1;
  localparam logic [1:0] DMS_GRP_LOW = 2'h0;
  localparam logic [1:0] DMS_GRP_HIGH = 2'h3;
  localparam logic [3:0] DMS_LOW_PAIR_IMM = 4'h1;
  localparam logic [3:0] DMS_LOW_PUSH = 4'h5;
  localparam logic [3:0] DMS_LOW_POP = 4'h1;
  localparam logic [1:0] DMS_RP_WORD = 2'h3;
  localparam logic [7:0] DMS_OP_SWAP = 8'heb;
  localparam logic [7:0] DMS_OP_MEM_MEM = 8'h76;

  // Sequencer states
  typedef enum logic [3:0] {
    DMS_ST_FETCH = 4'h0,
    DMS_ST_EXEC = 4'h1,
    DMS_ST_RD_HL = 4'h2,
    DMS_ST_WR_HL = 4'h3,
    DMS_ST_IMM_LO = 4'h4,
    DMS_ST_IMM_HI = 4'h5,
    DMS_ST_PUSH_HI = 4'h6,
    DMS_ST_PUSH_LO = 4'h7,
    DMS_ST_POP_LO = 4'h8,
    DMS_ST_POP_HI = 4'h9
  } dms_state_t;

  // System bus request, driven by the decoder
  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } dms_bus_req_t;

  // System bus answer from memory
  typedef struct packed {
    logic [7:0] rdata;
    logic ready;
  } dms_bus_rsp_t;

  // Programmer-visible state
  typedef struct packed {
    logic [7:0][7:0] regs;
    logic [15:0] sp;
    logic [15:0] pc;
  } dms_arch_t;

endpackage : dms_pkg

/* tb/dms_chk_sva.sv */
/*
  Port checker for the decoder, bound to every dms_decoder instance.
  Assumes the held-strobe bus with a one-cycle ready.
*/
`timescale 1ns/1ps
module dms_chk
  import dms_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input dms_bus_req_t o_bus,
  input dms_bus_rsp_t i_bus,
  input dms_arch_t o_arch,
  input wire logic o_unsupported
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // Bus completion, stack slot below the pointer, memory pointer
  wire logic done = (o_bus.rd | o_bus.wr) & i_bus.ready;
  wire logic [15:0] spm = o_arch.sp - 16'h0001;
  wire logic [15:0] hl = {o_arch.regs[DMS_IDX_H], o_arch.regs[DMS_IDX_L]};
  wire logic rd_done = o_bus.rd & i_bus.ready;
  wire logic pop = rd_done & o_bus.addr == o_arch.sp & o_bus.addr != o_arch.pc;
  a_rd_held: assert property (o_bus.rd && !i_bus.ready
    |=> o_bus.rd && $stable(o_bus.addr))
    else $error("read dropped early");
  a_wr_held: assert property (o_bus.wr && !i_bus.ready
    |=> o_bus.wr && $stable(o_bus.wdata))
    else $error("write dropped early");
  a_strobe_excl: assert property (!(o_bus.rd && o_bus.wr))
    else $error("read and write together");
  a_idle_gap: assert property (done |=> !(o_bus.rd || o_bus.wr))
    else $error("no idle cycle");
  a_wr_addr: assert property (o_bus.wr |-> o_bus.addr == spm || o_bus.addr == hl)
    else $error("bad write address");
  a_sp_dec: assert property (o_bus.wr && i_bus.ready && o_bus.addr == spm
    |=> o_arch.sp == $past(spm))
    else $error("push pointer");
  a_sp_inc: assert property (pop |=> o_arch.sp == $past(o_arch.sp) + 16'h0001)
    else $error("pop pointer");
  a_fetch_pc: assert property (rd_done && o_bus.addr == o_arch.pc
    |=> o_arch.pc == $past(o_arch.pc) + 16'h0001)
    else $error("pc step");
  a_unsup_pulse: assert property (o_unsupported |=> !o_unsupported)
    else $error("long pulse");
  c_write: cover property (o_bus.wr && i_bus.ready);
  c_pop: cover property (pop);
  c_unsup: cover property (o_unsupported);
endmodule : dms_chk

bind dms_decoder dms_chk u_dms_chk (.i_clk(i_clk), .i_reset_n(i_reset_n), .o_bus(o_bus),
  .i_bus(i_bus), .o_arch(o_arch), .o_unsupported(o_unsupported));

/* tb/dms_mem.sv */
/*
  Behavioural memory on the system bus.
  Assumes strobes held until ready; waits 0..3 cycles per access.
*/
`timescale 1ns/1ps
module dms_mem
  import dms_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input dms_bus_req_t i_req,
  output dms_bus_rsp_t o_rsp
);
  logic [7:0] mem [65536];
  logic [1:0] wait_cnt;
  // Answer each held strobe; read data garbled outside the answer
  always @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n)
    begin
      o_rsp <= '0;
      wait_cnt <= 2'h0;
    end
    else
    begin
      o_rsp.ready <= 1'b0;
      o_rsp.rdata <= ~o_rsp.rdata;
      if ((i_req.rd | i_req.wr) && !o_rsp.ready)
      begin
        if (wait_cnt != 2'h0)
          wait_cnt <= wait_cnt - 2'h1;
        else
        begin
          o_rsp.ready <= 1'b1;
          wait_cnt <= i_req.addr[1:0];
          if (i_req.rd)
            o_rsp.rdata <= mem[i_req.addr];
          if (i_req.wr)
            mem[i_req.addr] <= i_req.wdata;
        end
      end
    end
endmodule : dms_mem

/* tb/tb_top.sv */
/*
  Program-driven bench: loads, swap, copies, memory moves, pushes, pops.
  Assumes memory beyond the program reads zero (skipped opcodes).
*/
`timescale 1ns/1ps
module tb_top;
  import dms_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  dms_bus_req_t o_bus;
  dms_bus_rsp_t i_bus;
  dms_arch_t o_arch;
  logic o_unsupported;
  int fails = 0;
  int checked = 0;
  int seed = 32233;
  logic [23:0] q[$];
  logic [7:0] b, c, d, e, h, l;
  logic [7:0] prog [23];
  initial forever #2 i_clk = ~i_clk;
  dms_decoder u_dms_decoder (.i_clk(i_clk), .i_reset_n(i_reset_n), .o_bus(o_bus),
    .i_bus(i_bus), .o_arch(o_arch), .o_unsupported(o_unsupported));
  dms_mem u_dms_mem (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_req(o_bus), .o_rsp(i_bus));
  // Compare and count
  task chk(input logic [63:0] seen, input logic [63:0] exp, input string nm);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task report_and_stop;
    if (fails == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  // Each completed write against the oldest note
  always @(posedge i_clk)
    if (o_bus.wr && i_bus.ready)
      chk({o_bus.addr, o_bus.wdata}, q.size() ? q.pop_front() : 24'hx, "write");
  // Watchdog
  initial
  begin
    repeat (2000) @(posedge i_clk);
    fails++;
    report_and_stop();
  end
  // Main sequence
  initial
  begin
    b = $random(seed);
    c = $random(seed);
    d = 8'h40 | ($random(seed) & 8'h3f);
    e = $random(seed);
    h = $random(seed);
    l = $random(seed);
    prog = '{8'h21, l, h, 8'h11, e, d, 8'h01, c, b, 8'heb, 8'h7b, 8'h77, 8'h4e, 8'hc5,
      8'hf5, 8'hd5, 8'he5, 8'hc1, 8'hf1, 8'hd1, 8'he1, 8'he5, 8'h76};
    for (int i = 0; i < 65536; i++)
      u_dms_mem.mem[i] = (i < 23) ? prog[i] : 8'h00;
    q = '{{d, e, l}, {16'hffff, b}, {16'hfffe, l}, {16'hfffd, l}, {16'hfffc, 8'h00},
      {16'hfffb, h}, {16'hfffa, l}, {16'hfff9, d}, {16'hfff8, e}, {16'hffff, b},
      {16'hfffe, l}};
    repeat (6) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(posedge i_clk iff o_unsupported);
    #1;
    chk(o_arch.regs, {h, l, l, b, 8'h00, l, e, d}, "regs");
    chk(o_arch.sp, 16'hfffe, "sp");
    chk(o_arch.pc, 16'h0017, "pc");
    chk(q.size(), 0, "writes left");
    report_and_stop();
  end
endmodule : tb_top
